// ---- hdl/device_info_rom_map.sv ----
// APB slave exposing the revision word and the factory information area.
// Assumes a single pclk domain; pslverr flags writes other than to the address pointer with pstrb[2:0] all set, unmapped reads, and data reads outside the area.
`timescale 1ns/100ps
module device_info_rom_map #(
  parameter logic [5:0] MAJOR_REV = 6'h11, // Arbitrary value
  parameter logic [5:0] MINOR_REV = 6'h07, // Arbitrary value
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------
  // Combinational sources
  // ----------------------------------------
  info_pkg::revision_t rev;
  logic [15:0] rev_word;
  logic [21:0] info_addr_reg, info_addr_next;
  logic [4:0] idx;
  info_pkg::info_read_t rom_rd;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic setup;
  logic in_area;

  assign rev.major_rev_code = MAJOR_REV;
  assign rev.minor_rev_code = MINOR_REV;

  revision_word u_rev (
    .rev(rev),
    .word(rev_word)
  );

  assign in_area = info_addr_reg >= info_pkg::AREA_BASE && info_addr_reg <= info_pkg::AREA_LAST;
  always_comb begin
    idx = info_addr_reg[5:1];
    if (psel && paddr >= info_pkg::WINDOW_OFF && paddr <= info_pkg::WINDOW_LAST) begin
      idx = paddr[6:2];
    end
  end

  factory_info_rom #(
    .LOW_VOLTAGE(LOW_VOLTAGE)
  ) u_rom (
    .idx(idx),
    .rd(rom_rd)
  );

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  // No wait state: answer registered in setup, pready high in the first access cycle.
  assign setup = psel && !penable;
  always_comb begin
    info_addr_next = info_addr_reg;
    prdata_next = 32'h0000_0000;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (setup) begin
      pready_next = 1'b1;
      if (pwrite) begin
        // Only the address pointer is writable; area and revision ignore writes.
        if (paddr == info_pkg::INFO_ADDR_OFF && pstrb[2:0] == 3'h7) begin
          info_addr_next = pwdata[21:0];
        end else begin
          pslverr_next = 1'b1;
        end
      end else if (paddr == info_pkg::REVISION_OFF) begin
        prdata_next = {16'h0000, rev_word};
      end else if (paddr == info_pkg::INFO_ADDR_OFF) begin
        prdata_next = {10'h000, info_addr_reg};
      end else if (paddr == info_pkg::INFO_DATA_OFF) begin
        prdata_next = {15'h0000, rom_rd.valid && in_area, in_area ? rom_rd.data : 16'h0000};
        pslverr_next = !in_area;
      end else if (paddr >= info_pkg::WINDOW_OFF && paddr <= info_pkg::WINDOW_LAST && paddr[1:0] == 2'h0) begin
        prdata_next = {15'h0000, rom_rd.valid, rom_rd.data};
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      info_addr_reg <= info_pkg::INFO_ADDR_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      info_addr_reg <= info_addr_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

// ---- hdl/factory_info_rom.sv ----
// Read-only image of the factory information area.
// Assumes word index from the program address, bits 5..1, or from paddr bits 6..2 for window reads.
`timescale 1ns/100ps
module factory_info_rom #(
  parameter logic [95:0] UNIQUE_ID = 96'h0123_4567_89AB_CDEF_0011_2233,
  parameter logic [159:0] CUSTOMER_ID = {10{16'hFFFF}},
  parameter logic [15:0] TEMP_LOW = 16'h0000,
  parameter logic [15:0] TEMP_HIGH = 16'h0000,
  parameter logic [47:0] CONV_REF = {16'd4096, 16'd2048, 16'd1024},
  parameter logic [47:0] CMP_REF = {16'd4096, 16'd2048, 16'd1024},
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input wire logic [4:0] idx,
  output info_pkg::info_read_t rd
);
  // ----------------------------------------
  // Word lookup
  // ----------------------------------------
  // Pure lookup: no write path exists, so erase or modify is impossible.
  always_comb begin
    rd.valid = 1'b1;
    rd.data = info_pkg::RESERVED_WORD;
    if (idx <= info_pkg::UID_LAST) begin
      rd.data = UNIQUE_ID[16*idx[2:0] +: 16];
    end else if (idx >= info_pkg::CUID_FIRST && idx <= info_pkg::CUID_LAST) begin
      rd.data = CUSTOMER_ID[16*(idx - info_pkg::CUID_FIRST) +: 16];
    end else if (idx == info_pkg::TEMP_LOW_IDX) begin
      rd.data = TEMP_LOW;
    end else if (idx == info_pkg::TEMP_HIGH_IDX) begin
      rd.data = TEMP_HIGH;
    end else if (idx >= info_pkg::CONV_REF_IDX && idx < info_pkg::CMP_REF_IDX) begin
      rd.data = CONV_REF[16*(idx - info_pkg::CONV_REF_IDX) +: 16];
    end else if (idx == info_pkg::CMP_REF4_IDX && LOW_VOLTAGE) begin
      rd.valid = 1'b0;
    end else if (idx >= info_pkg::CMP_REF_IDX && idx <= info_pkg::CMP_REF4_IDX) begin
      rd.data = CMP_REF[16*(idx - info_pkg::CMP_REF_IDX) +: 16];
    end else begin
      rd.valid = 1'b0;
    end
  end
endmodule

// ---- hdl/info_pkg.sv ----
// Constants and types for the factory information area and revision word.
// Assumes a 32-bit APB slave and word-granular read access.
package info_pkg;

  // ----------------------------------------
  // Program memory map
  // ----------------------------------------
  localparam logic [21:0] AREA_BASE = 22'h3F0000;
  localparam logic [21:0] AREA_LAST = 22'h3F003F;
  localparam int AREA_WORDS = 32;
  localparam logic [4:0] UID_FIRST = 5'h00;
  localparam logic [4:0] UID_LAST = 5'h05;
  localparam logic [4:0] CUID_FIRST = 5'h08;
  localparam logic [4:0] CUID_LAST = 5'h11;
  localparam logic [4:0] TEMP_LOW_IDX = 5'h13;
  localparam logic [4:0] TEMP_HIGH_IDX = 5'h16;
  localparam logic [4:0] CONV_REF_IDX = 5'h18;
  localparam logic [4:0] CMP_REF_IDX = 5'h1B;
  localparam logic [4:0] CMP_REF4_IDX = 5'h1D;
  localparam logic [15:0] RESERVED_WORD = 16'hFFFF;

  // ----------------------------------------
  // Revision word layout
  // ----------------------------------------
  localparam int FAMILY_LSB = 12;
  localparam int MAJOR_LSB = 6;
  localparam int MINOR_LSB = 0;
  localparam logic [3:0] FAMILY_PATTERN = 4'h5; // Arbitrary value

  // ----------------------------------------
  // APB register map
  // ----------------------------------------
  localparam logic [11:0] REVISION_OFF = 12'h000;
  localparam logic [11:0] INFO_ADDR_OFF = 12'h004;
  localparam logic [11:0] INFO_DATA_OFF = 12'h008;
  localparam logic [11:0] WINDOW_OFF = 12'h100;
  localparam logic [11:0] WINDOW_LAST = 12'h17C;
  localparam logic [21:0] INFO_ADDR_RESET = 22'h3F0000;

  typedef struct packed {
    logic [5:0] major_rev_code;
    logic [5:0] minor_rev_code;
  } revision_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } info_read_t;

endpackage

// ---- hdl/revision_word.sv ----
// Builds the 16-bit revision word from the revision codes.
// Assumes codes are static for the life of the part.
`timescale 1ns/100ps
module revision_word (
  input wire info_pkg::revision_t rev,
  output logic [15:0] word
);
  assign word = {info_pkg::FAMILY_PATTERN, rev.major_rev_code, rev.minor_rev_code};
endmodule

// ---- sim/device_info_rom_map_tb_top.sv ----
// Self-checking bench for the information area APB slave.
// Assumes ROM contents at their default parameter values.
`timescale 1ns/100ps
module device_info_rom_map_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, lv_rd, rd, lv_cap;
  logic [3:0] pstrb = 4'hF;
  int n_fail = 0, checks_done = 0, cyc = 0;
  device_info_rom_map #(.MAJOR_REV(6'h2A), .MINOR_REV(6'h15)) device_info_rom_map_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  // Low-voltage part shares the bus; only its read data is watched
  device_info_rom_map #(.LOW_VOLTAGE(1'b1)) lv_device_info_rom_map_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata(lv_rd), .pready(), .pslverr());
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Answer taken at the rising edge that sees pready; one idle cycle keeps strobes single-assigned
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    lv_cap = lv_rd;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [16:0] exp_w(input int i);
    logic [95:0] uid;
    uid = 96'h0123_4567_89AB_CDEF_0011_2233;
    if (i < 6) return {1'b1, uid[16*i +: 16]};
    if (i >= 8 && i <= 17) return 17'h1FFFF;
    if (i == 19 || i == 22) return 17'h10000;
    if (i >= 24 && i <= 29) return {1'b1, 16'h0400 << ((i - 24) % 3)};
    return 17'h0FFFF;
  endfunction
  task automatic t_rev();
    apb(1'b0, 12'h000, 32'h0);
    chk({err, rd[15:0]}, 32'({1'b0, info_pkg::FAMILY_PATTERN, 6'h2A, 6'h15}));
    apb(1'b1, 12'h000, 32'hFFFF);
    chk(err, 1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[15:0], 32'({info_pkg::FAMILY_PATTERN, 6'h2A, 6'h15}));
  endtask
  task automatic t_area();
    for (int i = 0; i < 32; i++) begin
      apb(1'b0, 12'h100 + 12'(4 * i), 32'h0);
      chk({err, rd[16:0]}, exp_w(i));
      if (i == 29) chk(lv_cap[16:0], 32'h0FFFF);
    end
  endtask
  task automatic t_prot();
    apb(1'b1, 12'h100, 32'h0000_1234);
    chk(err, 1);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd[16:0], exp_w(0));
    apb(1'b1, 12'h004, 32'h003F_002C);
    chk(err, 0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h003F_002C);
    apb(1'b0, 12'h008, 32'h0);
    chk({err, rd[16:0]}, exp_w(22));
    apb(1'b1, 12'h004, 32'h003F_0040);
    apb(1'b0, 12'h008, 32'h0);
    chk(err, 1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1);
  endtask
  task automatic results();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_rev();
    t_area();
    t_prot();
    results();
  end
endmodule

// ---- sim/info_map_asserts.sv ----
// Checker for the information area APB slave.
// Assumes one pclk domain; bound to every instance of the top module.
`timescale 1ns/100ps
module info_map_asserts #(
  parameter logic [5:0] MAJOR_REV = 6'h11,
  parameter logic [5:0] MINOR_REV = 6'h07
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic win = paddr[11:7] == 5'h02;
  wire logic rev_rd = setup && !pwrite && paddr == 12'h000;
  property p_answer; setup |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_cause; pready |-> $past(setup) ##1 !pready; endproperty
  a_cause: assert property (p_cause) else $error("stray or long ready");
  property p_family; pready && $past(rev_rd) |-> !pslverr && prdata[15:12] == info_pkg::FAMILY_PATTERN; endproperty
  a_family: assert property (p_family) else $error("family pattern wrong");
  property p_major; pready && $past(rev_rd) |-> prdata[11:6] == MAJOR_REV; endproperty
  a_major: assert property (p_major) else $error("major code wrong");
  property p_minor; pready && $past(rev_rd) |-> prdata[5:0] == MINOR_REV; endproperty
  a_minor: assert property (p_minor) else $error("minor code wrong");
  property p_rev_ro; pready && $past(setup && pwrite && paddr == 12'h000) |-> pslverr; endproperty
  a_rev_ro: assert property (p_rev_ro) else $error("revision write accepted");
  property p_area_ro; pready && $past(setup && pwrite && win) |-> pslverr; endproperty
  a_area_ro: assert property (p_area_ro) else $error("area write accepted");
  property p_uid; pready && $past(setup && !pwrite && win && paddr[1:0] == 2'h0 && paddr[6:2] < 5'h06)
    |-> prdata[16] && !pslverr;
  endproperty
  a_uid: assert property (p_uid) else $error("id word not valid");
  property p_resv;
    pready && $past(setup && !pwrite && win && paddr[1:0] == 2'h0 && paddr[6:2] inside {6, 7, 18, 20, 21, 23, 30, 31})
      |-> prdata[16:0] == 17'h0FFFF;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved word wrong");
  c_ok: cover property (pready && !pslverr);
  c_err: cover property (pready && pslverr);
  c_b2b: cover property (pready ##[1:3] pready);
endmodule
bind device_info_rom_map info_map_asserts #(.MAJOR_REV(MAJOR_REV), .MINOR_REV(MINOR_REV)) info_map_asserts_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr);
